/* File: verilog/spc_pkg.sv */
// Constants, types and register map of the servo positioner control I/O.
// Assumes a single 25 MHz clock and an AHB-Lite register bus.
package spc_pkg;
    localparam int unsigned CLK_HZ = 25_000_000;
    localparam int unsigned STEP_US = 10;
    localparam int unsigned STEP_CYCLES = CLK_HZ / 1_000_000 * STEP_US;
    localparam int unsigned HOLD_TICK_MS = 1;
    localparam int unsigned HOLD_TICK_CYCLES = CLK_HZ / 1000 * HOLD_TICK_MS;
    localparam int unsigned POS_W = 16;
    localparam int unsigned PT_AW = 6;
    localparam int unsigned PT_DEPTH = 64;
    localparam int unsigned WIN_W = 15;
    localparam int unsigned HOLD_W = 16;
    // Register byte offsets
    localparam logic [7:0] OFF_MODE = 8'h00;
    localparam logic [7:0] OFF_WINDOW = 8'h04;
    localparam logic [7:0] OFF_HOLD = 8'h08;
    localparam logic [7:0] OFF_STATUS = 8'h0c;
    localparam logic [7:0] OFF_POSITION = 8'h10;
    localparam logic [7:0] OFF_HOME_COMP = 8'h14;
    localparam logic [7:0] OFF_TARGET = 8'h18;
    // Reset values
    localparam logic [7:0] MODE_RST = 8'h11;
    localparam logic [WIN_W-1:0] WINDOW_RST = 15'h0003;
    localparam logic [HOLD_W-1:0] HOLD_RST = 16'h0064;
    localparam logic [POS_W-1:0] POS_RST = 16'h0000;
    // Control modes
    localparam logic [7:0] MODE_POINT = 8'h11;
    localparam logic [7:0] MODE_POINT_FEED = 8'h12;
    localparam logic [7:0] MODE_DIRECT = 8'h13;
    localparam logic [7:0] MODE_DIRECT_FEED = 8'h14;
    // Packed control input bit positions
    localparam int unsigned IN_RUN = 0;
    localparam int unsigned IN_START = 1;
    localparam int unsigned IN_CLEAR = 2;
    localparam int unsigned IN_HOME = 3;
    localparam int unsigned IN_JOG_FWD = 4;
    localparam int unsigned IN_JOG_REV = 5;
    localparam int unsigned IN_CAPTURE = 6;
    localparam int unsigned IN_SEL_LSB = 7;
    localparam int unsigned IN_FWD_OK = 15;
    localparam int unsigned IN_REV_OK = 16;
    localparam int unsigned IN_PROX = 17;
    localparam int unsigned IN_DECEL = 18;
    localparam int unsigned IN_W = 19;
    localparam logic [IN_W-1:0] IN_RST = 19'h00000;
    localparam logic [1:0] HTRANS_IDLE = 2'h0;
    typedef enum logic [2:0] {
        ST_IDLE, ST_FETCH, ST_MOVE, ST_JOG, ST_HOME
    } spc_state_t;
endpackage : spc_pkg

/* File: verilog/spc_mem_if.sv */
// Port bundle between the controller and the point data memory.
// Assumes both ends sit on the same clock.
interface spc_mem_if;
    logic we;
    logic [spc_pkg::PT_AW-1:0] waddr;
    logic [spc_pkg::POS_W-1:0] wdata;
    logic [spc_pkg::PT_AW-1:0] raddr;
    logic [spc_pkg::POS_W-1:0] rdata;
    modport ctrl (output we, output waddr, output wdata, output raddr,
                  input rdata);
    modport mem (input we, input waddr, input wdata, input raddr,
                 output rdata);
endinterface : spc_mem_if

/* File: verilog/spc_point_mem.sv */
// Point data store: one position word per point, registered read.
// Assumes the controller drives the port on the same clock.
module spc_point_mem (
    // Clock and reset
    input logic hclk,
    input logic hresetn,
    // Memory port
    spc_mem_if.mem mp
);
    import spc_pkg::*;

    logic [POS_W-1:0] store [PT_DEPTH];

    // Array has no reset; contents are undefined until captured
    always_ff @(posedge hclk) begin
        if (mp.we) begin
            store[mp.waddr] <= mp.wdata;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            mp.rdata <= POS_RST;
        end else begin
            mp.rdata <= store[mp.raddr];
        end
    end
endmodule : spc_point_mem

/* File: verilog/spc_control_io.sv */
// Discrete control I/O of the servo positioner with AHB-Lite registers.
// Assumes control pins are asynchronous to hclk; bus is on hclk.
module spc_control_io #(
    parameter int unsigned HOLD_TICK_CYCLES = spc_pkg::HOLD_TICK_CYCLES
) (
    // Clock and reset
    input logic hclk,
    input logic hresetn,
    // AHB-Lite slave
    input logic hsel,
    input logic [31:0] haddr,
    input logic [1:0] htrans,
    input logic hwrite,
    input logic [2:0] hsize,
    input logic [31:0] hwdata,
    input logic hready,
    output logic hreadyout,
    output logic [31:0] hrdata,
    output logic hresp,
    // Control inputs from the host
    input logic run,
    input logic start,
    input logic alarm_clear,
    input logic home_search,
    input logic jog_fwd,
    input logic jog_rev,
    input logic capture_command,
    input logic [7:0] point_select_in,
    input logic forward_limit_ok,
    input logic reverse_limit_ok,
    input logic home_proximity,
    input logic decel_stop_n,
    // Control outputs to the host
    output logic ready,
    output logic home_done,
    output logic home_stop,
    output logic capture_done,
    output logic motor_powered,
    output logic position_settled,
    output logic alarm_n,
    output logic [6:0] point_code_out,
    output logic brake_timing_out
);
    import spc_pkg::*;

    localparam int unsigned TICK_W = $clog2(HOLD_TICK_CYCLES);
    localparam int unsigned STEP_W = $clog2(STEP_CYCLES);

    spc_mem_if mem_bus ();

    spc_point_mem u_mem (
        .hclk(hclk),
        .hresetn(hresetn),
        .mp(mem_bus.mem)
    );

    // Input synchroniser
    logic [IN_W-1:0] pins_raw;
    logic [IN_W-1:0] sync_a;
    logic [IN_W-1:0] sync_b;
    logic [IN_W-1:0] prev_b;
    logic [IN_W-1:0] rise;

    assign pins_raw = {decel_stop_n, home_proximity, reverse_limit_ok,
                       forward_limit_ok, point_select_in, capture_command,
                       jog_rev, jog_fwd, home_search, alarm_clear, start,
                       run};

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            sync_a <= IN_RST;
            sync_b <= IN_RST;
            prev_b <= IN_RST;
        end else begin
            sync_a <= pins_raw;
            sync_b <= sync_a;
            prev_b <= sync_b;
        end
    end

    assign rise = sync_b & ~prev_b;

    // Decoded inputs
    wire powered = sync_b[IN_RUN];
    wire jf_s = sync_b[IN_JOG_FWD];
    wire jr_s = sync_b[IN_JOG_REV];
    wire fwd_ok = sync_b[IN_FWD_OK];
    wire rev_ok = sync_b[IN_REV_OK];
    wire prox_s = sync_b[IN_PROX];
    wire run_allowed = sync_b[IN_DECEL];
    wire [7:0] sel = sync_b[IN_SEL_LSB +: 8];

    // Registers
    logic [7:0] mode;
    logic [WIN_W-1:0] window;
    logic [HOLD_W-1:0] hold_time;
    logic [POS_W-1:0] home_comp;
    logic [POS_W-1:0] pos;
    logic [POS_W-1:0] next_pos;
    logic [POS_W-1:0] target;
    logic [POS_W-1:0] next_target;
    spc_state_t state;
    spc_state_t next_state;
    logic alarm;
    logic home_standby;
    logic [6:0] cmd_hi;
    logic [6:0] cmd_lo;
    logic [6:0] pcode;
    logic [HOLD_W-1:0] hold_cnt;

    wire is_point = (mode == MODE_POINT) || (mode == MODE_POINT_FEED);
    wire is_direct = (mode == MODE_DIRECT) || (mode == MODE_DIRECT_FEED);

    // BCD decode of the select inputs
    wire [6:0] point_value = 7'(sel[6:4]) * 7'h0a + 7'(sel[3:0]);
    wire point_ok = (sel[3:0] <= 4'h9) && (point_value >= 7'h01)
                    && (point_value <= 7'h40);
    wire [PT_AW-1:0] point_idx = PT_AW'(point_value - 7'h01);
    wire [6:0] block_value = 7'(sel[7:4]) * 7'h0a + 7'(sel[3:0]);
    wire block_ok = (sel[7:4] <= 4'h9) && (sel[3:0] <= 4'h9);
    wire [POS_W-1:0] direct_target =
        POS_W'(14'(cmd_hi) * 14'h0064 + 14'(cmd_lo));

    // Step rate divider
    logic [STEP_W-1:0] step_cnt;
    wire step_en = (step_cnt == STEP_W'(STEP_CYCLES - 1));

    // Hold time tick divider
    logic [TICK_W-1:0] tick_cnt;
    wire tick_en = (tick_cnt == TICK_W'(HOLD_TICK_CYCLES - 1));

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            step_cnt <= '0;
            tick_cnt <= '0;
        end else begin
            step_cnt <= step_en ? '0 : step_cnt + 1'b1;
            tick_cnt <= tick_en ? '0 : tick_cnt + 1'b1;
        end
    end

    // Deviation and motion direction
    wire signed [POS_W:0] dev = $signed({target[POS_W-1], target})
                                - $signed({pos[POS_W-1], pos});
    wire [POS_W:0] abs_dev = dev[POS_W] ? -dev : dev;
    wire settled_now = abs_dev < (POS_W+1)'(window);
    wire at_target = (dev == '0);
    wire want_fwd = ((state == ST_MOVE) && !dev[POS_W] && !at_target)
                    || ((state == ST_JOG) && jf_s);
    wire want_rev = ((state == ST_MOVE) && dev[POS_W])
                    || ((state == ST_JOG) && jr_s && !jf_s)
                    || (state == ST_HOME);
    wire limit_hit = (want_fwd && !fwd_ok) || (want_rev && !rev_ok);
    wire alarm_set = powered && step_en && limit_hit;
    wire motion_ok = powered && !alarm && run_allowed;
    wire ready_now = motion_ok && (state == ST_IDLE);
    wire start_go = ready_now && rise[IN_START];
    wire home_go = ready_now && rise[IN_HOME];
    wire home_active = (state == ST_HOME) || home_standby;
    wire cap_go = rise[IN_CAPTURE] && (ready_now || home_standby);
    wire home_found = motion_ok && (state == ST_HOME) && prox_s;
    wire [POS_W-1:0] step_pos = want_fwd ? pos + 1'b1 : pos - 1'b1;

    // Positioning sequencer
    always_comb begin
        next_state = state;
        next_pos = pos;
        next_target = target;
        if (!motion_ok) begin
            next_state = ST_IDLE;
            next_target = pos;
        end else begin
            case (state)
                ST_IDLE: begin
                    if (home_go) begin
                        next_state = ST_HOME;
                    end else if (start_go && is_point && point_ok) begin
                        next_state = ST_FETCH;
                    end else if (start_go && is_direct) begin
                        next_target = direct_target;
                        next_state = ST_MOVE;
                    end else if (jf_s || jr_s) begin
                        next_state = ST_JOG;
                    end
                end
                ST_FETCH: begin
                    next_target = mem_bus.rdata;
                    next_state = ST_MOVE;
                end
                ST_MOVE: begin
                    if (at_target) begin
                        next_state = ST_IDLE;
                    end else if (step_en && !limit_hit) begin
                        next_pos = step_pos;
                    end
                end
                ST_JOG: begin
                    if (!jf_s && !jr_s) begin
                        next_state = ST_IDLE;
                    end else if (step_en && !limit_hit) begin
                        next_pos = step_pos;
                    end
                    next_target = next_pos;
                end
                ST_HOME: begin
                    if (prox_s) begin
                        next_pos = home_comp;
                        next_state = ST_IDLE;
                    end else if (step_en && !limit_hit) begin
                        next_pos = step_pos;
                    end
                    next_target = next_pos;
                end
                default: begin
                    next_state = ST_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state <= ST_IDLE;
            pos <= POS_RST;
            target <= POS_RST;
        end else begin
            state <= next_state;
            pos <= next_pos;
            target <= next_target;
        end
    end

    // Alarm: a new limit event wins over a clear in the same cycle
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            alarm <= 1'b0;
        end else if (alarm_set) begin
            alarm <= 1'b1;
        end else if (sync_b[IN_CLEAR]) begin
            alarm <= 1'b0;
        end
    end

    // Home search bookkeeping
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            home_standby <= 1'b0;
            home_done <= 1'b0;
        end else begin
            if (rise[IN_HOME] && !powered) begin
                home_standby <= 1'b1;
            end else if (!sync_b[IN_HOME] || powered) begin
                home_standby <= 1'b0;
            end
            if (home_found) begin
                home_done <= 1'b1;
            end else if (home_go) begin
                home_done <= 1'b0;
            end
        end
    end

    // Capture command
    assign mem_bus.we = cap_go && !home_active && is_point && point_ok;
    assign mem_bus.waddr = point_idx;
    assign mem_bus.wdata = pos;
    assign mem_bus.raddr = point_idx;
    wire cap_home = cap_go && home_active;
    wire cap_block = cap_go && !home_active && is_direct && block_ok;
    wire cap_stored = cap_home || mem_bus.we || cap_block;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            home_comp <= POS_RST;
            cmd_hi <= '0;
            cmd_lo <= '0;
            capture_done <= 1'b0;
        end else begin
            if (cap_home) begin
                home_comp <= pos;
            end
            if (cap_block) begin
                cmd_hi <= cmd_lo;
                cmd_lo <= block_value;
            end
            if (cap_stored) begin
                capture_done <= 1'b1;
            end else if (!sync_b[IN_CAPTURE]) begin
                capture_done <= 1'b0;
            end
        end
    end

    // Point code output with hold timer; zero hold keeps it on
    wire pcode_load = start_go && is_point && point_ok;
    wire pcode_expire = tick_en && (hold_cnt == 16'h0001);

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pcode <= '0;
            hold_cnt <= '0;
        end else if (pcode_load) begin
            pcode <= sel[6:0];
            hold_cnt <= hold_time;
        end else if (pcode_expire) begin
            pcode <= '0;
            hold_cnt <= '0;
        end else if (tick_en && (hold_cnt > 16'h0001)) begin
            hold_cnt <= hold_cnt - 1'b1;
        end
    end

    // Registered control outputs
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ready <= 1'b0;
            home_stop <= 1'b0;
            motor_powered <= 1'b0;
            position_settled <= 1'b0;
            alarm_n <= 1'b1;
            point_code_out <= '0;
            brake_timing_out <= 1'b0;
        end else begin
            ready <= ready_now;
            home_stop <= home_done && prox_s && (state == ST_IDLE);
            motor_powered <= powered;
            position_settled <= settled_now;
            alarm_n <= !alarm;
            point_code_out <= is_point ? pcode : 7'h00;
            brake_timing_out <= powered;
        end
    end

    // AHB-Lite slave, zero wait states
    wire ahb_go = hsel && hready && (htrans != HTRANS_IDLE);
    logic wr_pend;
    logic [7:0] wr_addr;
    logic [31:0] rd_mux;

    assign rd_mux =
        (haddr[7:0] == OFF_MODE) ? {24'h0, mode} :
        (haddr[7:0] == OFF_WINDOW) ? {17'h0, window} :
        (haddr[7:0] == OFF_HOLD) ? {16'h0, hold_time} :
        (haddr[7:0] == OFF_STATUS) ? {24'h0, 3'(state), home_standby,
                                      alarm, home_done, capture_done,
                                      powered} :
        (haddr[7:0] == OFF_POSITION) ? {16'h0, pos} :
        (haddr[7:0] == OFF_HOME_COMP) ? {16'h0, home_comp} :
        (haddr[7:0] == OFF_TARGET) ? {16'h0, target} :
        32'h0;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend <= 1'b0;
            wr_addr <= '0;
            hrdata <= '0;
            hreadyout <= 1'b1;
            hresp <= 1'b0;
        end else begin
            wr_pend <= ahb_go && hwrite;
            wr_addr <= haddr[7:0];
            hrdata <= (ahb_go && !hwrite) ? rd_mux : 32'h0;
            hreadyout <= 1'b1;
            hresp <= 1'b0;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            mode <= MODE_RST;
            window <= WINDOW_RST;
            hold_time <= HOLD_RST;
        end else if (wr_pend) begin
            if (wr_addr == OFF_MODE) begin
                mode <= hwdata[7:0];
            end
            if (wr_addr == OFF_WINDOW) begin
                window <= hwdata[WIN_W-1:0];
            end
            if (wr_addr == OFF_HOLD) begin
                hold_time <= hwdata[HOLD_W-1:0];
            end
        end
    end
endmodule : spc_control_io

/* File: test/spc_control_io_sva.sv */
// Checker for the control I/O block, bound to its top module.
// Assumes a pin change reaches the outputs three edges later.
module spc_control_io_sva (
    // Clock and reset
    input logic hclk,
    input logic hresetn,
    // Bus
    input logic hsel,
    input logic hready,
    input logic [1:0] htrans,
    input logic hwrite,
    input logic hreadyout,
    input logic [31:0] hrdata,
    input logic hresp,
    // Pins
    input logic run,
    input logic capture_command,
    input logic home_proximity,
    input logic ready,
    input logic home_stop,
    input logic capture_done,
    input logic motor_powered,
    input logic brake_timing_out
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);
    sequence s_run_rise;
        !run ##1 run;
    endsequence
    sequence s_run_fall;
        run ##1 !run;
    endsequence
    a_zero_wait: assert property (hreadyout)
        else $error("hreadyout low");
    a_resp_okay: assert property (!hresp)
        else $error("hresp not okay");
    a_data_idle: assert property (
        !(hsel && hready && htrans != 2'h0 && !hwrite) |=> hrdata == 32'h0)
        else $error("hrdata not zero outside read");
    a_power_up: assert property (
        s_run_rise |-> ##3 motor_powered && brake_timing_out)
        else $error("power not up three edges after run");
    a_power_down: assert property (
        s_run_fall |-> ##3 !motor_powered && !brake_timing_out)
        else $error("power not down three edges after run");
    a_brake_follows: assert property (
        brake_timing_out == motor_powered)
        else $error("brake timing differs from power");
    a_ready_powered: assert property (ready |-> motor_powered)
        else $error("ready without motor power");
    a_home_stop_prox: assert property (
        home_stop |-> $past(home_proximity, 3))
        else $error("home stop without proximity");
    a_capture_held: assert property (
        capture_done |-> $past(capture_command, 3))
        else $error("capture done after command dropped");
endmodule : spc_control_io_sva

/* File: test/spc_host_model.sv */
// Host controller model driving the discrete control lines.
// Assumes the device samples the lines as plain levels on hclk.
module spc_host_model (
    // Clock
    input logic hclk,
    // Control lines
    output logic [spc_pkg::IN_W-1:0] pin
);
    timeunit 1ns;
    timeprecision 1ns;
    import spc_pkg::*;
    // Limits released and decel high so the axis may move
    initial pin = IN_RST | (19'h1 << IN_FWD_OK) | (19'h1 << IN_REV_OK)
        | (19'h1 << IN_DECEL);
    task put(input int unsigned i, input logic v);
        @(posedge hclk);
        pin[i] <= v;
    endtask : put
    // Nibbles stay BCD unless a test means otherwise
    task select(input logic [7:0] bcd);
        @(posedge hclk);
        pin[IN_SEL_LSB +: 8] <= bcd;
    endtask : select
endmodule : spc_host_model

/* File: test/tb.sv */
// Self-checking bench for the control I/O block.
// Assumes one clock; the host model drives every control pin.
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin \
    miscompares++; $display("CHECK FAILED %0t %h not %h", $time, g, e); \
    end end
module tb;
    timeunit 1ns;
    timeprecision 1ns;
    import spc_pkg::*;
    logic hclk = 1'b0;
    logic hresetn = 1'b0;
    logic hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0] htrans = HTRANS_IDLE;
    logic hwrite = 1'b0;
    logic [2:0] hsize = 3'h2;
    logic [31:0] hwdata = 32'h0;
    logic hready, hreadyout, hresp, ready, home_done, home_stop;
    logic capture_done, motor_powered, position_settled, alarm_n;
    logic brake_timing_out;
    logic [31:0] hrdata, rdv;
    logic [6:0] point_code_out;
    logic [IN_W-1:0] pin;
    int miscompares = 0;
    int check_count = 0;
    int w;
    int unsigned lim[2] = '{IN_FWD_OK, IN_REV_OK};
    int unsigned jog[2] = '{IN_JOG_FWD, IN_JOG_REV};
    assign hready = hreadyout;
    always #20 hclk = ~hclk;
    spc_host_model u_spc_host_model (.hclk, .pin);
    spc_control_io #(.HOLD_TICK_CYCLES(10)) u_spc_control_io (
        .hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
        .hready, .hreadyout, .hrdata, .hresp,
        .run(pin[IN_RUN]), .start(pin[IN_START]),
        .alarm_clear(pin[IN_CLEAR]), .home_search(pin[IN_HOME]),
        .jog_fwd(pin[IN_JOG_FWD]), .jog_rev(pin[IN_JOG_REV]),
        .capture_command(pin[IN_CAPTURE]),
        .point_select_in(pin[IN_SEL_LSB +: 8]),
        .forward_limit_ok(pin[IN_FWD_OK]), .reverse_limit_ok(pin[IN_REV_OK]),
        .home_proximity(pin[IN_PROX]), .decel_stop_n(pin[IN_DECEL]),
        .ready, .home_done, .home_stop, .capture_done, .motor_powered,
        .position_settled, .alarm_n, .point_code_out, .brake_timing_out);
    task bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge hclk);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= {24'h0, a};
        hwrite <= wr;
        do @(posedge hclk); while (hready !== 1'b1);
        hsel <= 1'b0;
        htrans <= HTRANS_IDLE;
        hwdata <= d;
        do @(posedge hclk); while (hready !== 1'b1);
        rdv = hrdata;
    endtask : bus
    task rd(input logic [7:0] a, input logic [31:0] e);
        bus(1'b0, a, 32'h0);
        `CHK(rdv, e)
    endtask : rd
    task drive(input int unsigned i, input logic v);
        u_spc_host_model.put(i, v);
    endtask : drive
    task waitc(input int n);
        repeat (n) @(posedge hclk);
    endtask : waitc
    task take(input logic [7:0] b);
        u_spc_host_model.select(b);
        drive(IN_CAPTURE, 1'b1);
        for (w = 0; w < 20 && capture_done !== 1'b1; w++) @(posedge hclk);
        `CHK(capture_done, 1'b1)
        drive(IN_CAPTURE, 1'b0);
        waitc(6);
        `CHK(capture_done, 1'b0)
    endtask : take
    task move;
        drive(IN_START, 1'b1);
        for (w = 0; w < 20 && ready !== 1'b0; w++) @(posedge hclk);
        drive(IN_START, 1'b0);
        for (w = 0; w < 4000 && ready !== 1'b1; w++) @(posedge hclk);
        `CHK(ready, 1'b1)
    endtask : move
    task results;
        $display("Checks %0d, mismatches %0d", check_count, miscompares);
        if (miscompares == 0 && check_count > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : results
    // Full run is near 6500 cycles; this leaves ample margin
    initial begin
        #1_000_000;
        miscompares++;
        results();
    end
    initial begin
        repeat (3) @(posedge hclk);
        hresetn <= 1'b1;
        `CHK({alarm_n, motor_powered}, 2'b10)
        rd(OFF_MODE, {24'h0, MODE_RST});
        rd(OFF_WINDOW, {17'h0, WINDOW_RST});
        rd(OFF_HOLD, {16'h0, HOLD_RST});
        rd(8'h1c, 32'h0);
        for (int m = 8'h11; m <= 8'h14; m++) begin
            bus(1'b1, OFF_MODE, m);
            rd(OFF_MODE, m);
        end
        bus(1'b1, OFF_HOLD, 32'h0);
        drive(IN_HOME, 1'b1);
        waitc(6);
        bus(1'b0, OFF_STATUS, 32'h0);
        `CHK(rdv[4], 1'b1)
        drive(IN_HOME, 1'b0);
        drive(IN_RUN, 1'b1);
        waitc(6);
        `CHK({motor_powered, brake_timing_out, ready}, 3'b111)
        bus(1'b1, OFF_MODE, {24'h0, MODE_DIRECT});
        take(8'h00);
        take(8'h12);
        move();
        rd(OFF_POSITION, 32'd12);
        rd(OFF_TARGET, 32'd12);
        `CHK(position_settled, 1'b1)
        bus(1'b1, OFF_WINDOW, 32'h0);
        waitc(4);
        `CHK(position_settled, 1'b0)
        bus(1'b1, OFF_WINDOW, {17'h0, WINDOW_RST});
        bus(1'b1, OFF_MODE, {24'h0, MODE_POINT});
        take(8'h07);
        drive(IN_JOG_FWD, 1'b1);
        waitc(1000);
        drive(IN_JOG_FWD, 1'b0);
        waitc(10);
        bus(1'b0, OFF_POSITION, 32'h0);
        `CHK(rdv > 32'd12, 1'b1)
        u_spc_host_model.select(8'h07);
        move();
        rd(OFF_POSITION, 32'd12);
        `CHK(point_code_out, 7'h07)
        // Short hold: the point code must drop after two ticks
        bus(1'b1, OFF_HOLD, 32'h2);
        move();
        `CHK(point_code_out, 7'h07)
        waitc(30);
        `CHK(point_code_out, 7'h00)
        // Not BCD, so the start must be ignored
        u_spc_host_model.select(8'h1a);
        drive(IN_START, 1'b1);
        waitc(8);
        `CHK(ready, 1'b1)
        `CHK(point_code_out, 7'h00)
        drive(IN_START, 1'b0);
        drive(IN_DECEL, 1'b0);
        waitc(6);
        `CHK(ready, 1'b0)
        drive(IN_DECEL, 1'b1);
        waitc(6);
        `CHK(ready, 1'b1)
        for (int d = 0; d < 2; d++) begin
            drive(lim[d], 1'b0);
            drive(jog[d], 1'b1);
            for (w = 0; w < 600 && alarm_n !== 1'b0; w++) @(posedge hclk);
            `CHK({alarm_n, ready}, 2'b00)
            drive(jog[d], 1'b0);
            drive(lim[d], 1'b1);
            drive(IN_CLEAR, 1'b1);
            waitc(6);
            drive(IN_CLEAR, 1'b0);
            `CHK({alarm_n, motor_powered}, 2'b11)
        end
        // Unpowered standby capture sets the home compensation
        drive(IN_RUN, 1'b0);
        drive(IN_HOME, 1'b1);
        waitc(6);
        take(8'h00);
        rd(OFF_HOME_COMP, 32'd12);
        drive(IN_HOME, 1'b0);
        drive(IN_RUN, 1'b1);
        waitc(6);
        // Long enough for the search to step away from 12
        drive(IN_HOME, 1'b1);
        waitc(600);
        bus(1'b0, OFF_POSITION, 32'h0);
        `CHK(rdv < 32'd12, 1'b1)
        drive(IN_PROX, 1'b1);
        for (w = 0; w < 600 && home_done !== 1'b1; w++) @(posedge hclk);
        `CHK(home_done, 1'b1)
        waitc(6);
        `CHK(home_stop, 1'b1)
        rd(OFF_POSITION, 32'd12);
        drive(IN_PROX, 1'b0);
        waitc(6);
        `CHK(home_stop, 1'b0)
        drive(IN_HOME, 1'b0);
        drive(IN_RUN, 1'b0);
        waitc(6);
        `CHK({motor_powered, brake_timing_out}, 2'b00)
        results();
    end
endmodule : tb
bind spc_control_io spc_control_io_sva u_spc_control_io_sva (
    .hclk, .hresetn, .hsel, .hready, .htrans, .hwrite, .hreadyout, .hrdata,
    .hresp, .run, .capture_command, .home_proximity, .ready, .home_stop,
    .capture_done, .motor_powered, .brake_timing_out);
